// ===== core/discharge_time_measurement_sequencer.sv
// Discharge-time capacitance and resistance measurement sequencer
// Assumes opcode strobes and config writes arrive decoded on clk_sys;
// comparator_in is asynchronous from the analog front end
`include "seq_defs.svh"
module discharge_time_measurement_sequencer #(
	parameter int TIME_W = 16,
	parameter int ACC_W = 20,
	parameter int RES_W = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire seq_pkg::cfg_write_type cfg_write,
	input wire logic start_measurement,
	input wire logic start_temperature,
	input wire logic [5:0] rd_addr,
	output logic [23:0] rd_data,
	input wire logic comparator_in,
	output seq_pkg::frontend_type frontend,
	output logic discharge_en,
	output logic [1:0] discharge_resistor_select,
	output logic interrupt_out_n
);
	import seq_pkg::*;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic frontend_type cap_frontend(input logic [2:0] p, input logic [1:0] ph,
			input logic comp, input logic floating);
		frontend_type f;
		f = '0;
		if (!comp) begin
			f.capacitive_port[p] = 1'b1;
			f.sensor_switch_high = !floating || ph != 2'h1;
			f.sensor_switch_low = floating && ph != 2'h0;
		end
		return f;
	endfunction

	function automatic frontend_type temp_frontend(input logic ref_phase, input logic ext);
		frontend_type f;
		f = '0;
		if (ext) begin
			f.resistive_port[ref_phase ? `RPORT_EXT_REF : `RPORT_EXT_SENSOR] = 1'b1;
		end else begin
			f.resistive_port[ref_phase ? `RPORT_INT_POLY : `RPORT_INT_AL] = 1'b1;
		end
		return f;
	endfunction

	function automatic logic [ACC_W-1:0] comp_sub(input logic [ACC_W-1:0] a,
			input logic [ACC_W-1:0] b);
		return (a > b) ? a - b : '0;
	endfunction

	// ****************************************
	// Configuration and result read
	// ****************************************
	logic [23:0] meas_config_a, meas_config_b, temperature_config;
	logic [23:0] next_meas_config_a, next_meas_config_b, next_temperature_config;
	logic [23:0] next_rd_data;
	logic [RES_W-1:0] cap_result [1:7];
	logic [RES_W-1:0] external_temp_ratio_result, internal_temp_ratio_result;
	logic busy, timeout_flag;

	always_comb begin
		next_meas_config_a = meas_config_a;
		next_meas_config_b = meas_config_b;
		next_temperature_config = temperature_config;
		if (cfg_write.en) begin
			unique case (cfg_write.addr)
				`ADDR_MEAS_CONFIG_A: next_meas_config_a = cfg_write.data;
				`ADDR_MEAS_CONFIG_B: next_meas_config_b = cfg_write.data;
				`ADDR_TEMP_CONFIG: next_temperature_config = cfg_write.data;
				default: ;
			endcase
		end
		next_rd_data = '0;
		if (rd_addr == `ADDR_STATUS) begin
			next_rd_data[`STAT_BUSY] = busy;
			next_rd_data[`STAT_TIMEOUT] = timeout_flag;
		end else if (rd_addr >= `ADDR_CAP_FIRST && rd_addr <= `ADDR_CAP_LAST) begin
			next_rd_data = cap_result[rd_addr[2:0]];
		end else if (rd_addr == `ADDR_EXT_TEMP) begin
			next_rd_data = external_temp_ratio_result;
		end else if (rd_addr == `ADDR_INT_TEMP) begin
			next_rd_data = internal_temp_ratio_result;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meas_config_a <= '0;
			meas_config_b <= '0;
			temperature_config <= '0;
			rd_data <= '0;
		end else begin
			meas_config_a <= next_meas_config_a;
			meas_config_b <= next_meas_config_b;
			temperature_config <= next_temperature_config;
			rd_data <= next_rd_data;
		end
	end

	assign discharge_resistor_select = meas_config_b[`RES_SEL_MSB:`RES_SEL_LSB];

	// ****************************************
	// Configuration fields
	// ****************************************
	logic [TIME_W-1:0] cycle_time_setting, cycle_limit;
	logic floating, temp_trigger_cap, temp_ext;
	logic [2:0] sensors, last_port;
	logic [3:0] avg_size;
	logic [4:0] total_blocks, fake_blocks;
	logic [9:0] temp_trigger_divider;

	assign cycle_time_setting = meas_config_a[`CYCLE_TIME_MSB:`CYCLE_TIME_LSB];
	assign cycle_limit = (cycle_time_setting == '0) ? TIME_W'(1) : cycle_time_setting;
	assign floating = meas_config_b[`FLOATING_BIT];
	assign sensors = meas_config_b[`SENSORS_MSB:`SENSORS_LSB];
	assign last_port = (sensors == 3'h0) ? 3'h1 :
		(floating && sensors > `MAX_FLOAT_SENSORS) ? `MAX_FLOAT_SENSORS : sensors;
	assign avg_size = meas_config_b[`AVG_MSB:`AVG_LSB];
	assign fake_blocks = {3'h0, meas_config_b[`FAKE_MSB:`FAKE_LSB]};
	assign total_blocks = fake_blocks + ((avg_size == 4'h0) ? 5'h01 : {1'b0, avg_size});
	assign temp_trigger_cap = meas_config_a[`TRIG_SRC_MSB:`TRIG_SRC_LSB] == `TRIG_SRC_CAP;
	assign temp_trigger_divider = meas_config_b[`TRIG_DIV_MSB:`TRIG_DIV_LSB];
	assign temp_ext = temperature_config[`TEMP_SEL_MSB:`TEMP_SEL_LSB] == `TEMP_SEL_EXT;

	// ****************************************
	// Comparator synchroniser
	// ****************************************
	logic comp_meta, comp_sync;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// Idle comparator level, so no false discharge after reset
			comp_meta <= 1'b1;
			comp_sync <= 1'b1;
		end else begin
			comp_meta <= comparator_in;
			comp_sync <= comp_meta;
		end
	end

	// ****************************************
	// Timer and divider
	// ****************************************
	logic launch, next_launch, div_go, next_div_go;
	logic t_done, t_to, d_done;
	logic [TIME_W-1:0] t_time;
	logic [ACC_W-1:0] div_num, div_den;
	logic [RES_W-1:0] d_quo;

	discharge_timer #(.TIME_W(TIME_W)) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(launch),
		.cycle_limit(cycle_limit),
		.comp_high(comp_sync),
		.discharge_en(discharge_en),
		.done(t_done),
		.time_val(t_time),
		.timed_out(t_to)
	);

	ratio_divider #(.NUM_W(ACC_W), .FRAC_W(`FRAC_BITS), .OUT_W(RES_W)) u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(div_go),
		.numer(div_num),
		.denom(div_den),
		.done(d_done),
		.quotient(d_quo)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	seq_state_type state, next_state;
	logic [2:0] port, next_port;
	logic [1:0] phase, next_phase;
	logic in_comp, next_in_comp, temp_phase, next_temp_phase;
	logic [4:0] block_cnt, next_block_cnt;
	logic [9:0] temp_div_cnt, next_temp_div_cnt;
	logic [ACC_W-1:0] acc [0:7];
	logic [ACC_W-1:0] next_acc [0:7];
	logic [ACC_W-1:0] comp_acc, next_comp_acc;
	logic [TIME_W-1:0] temp_sensor_time, next_temp_sensor_time;
	logic [TIME_W-1:0] temp_ref_time, next_temp_ref_time;
	logic [RES_W-1:0] next_cap_result [1:7];
	logic [RES_W-1:0] next_ext_result, next_int_result;
	logic next_busy, next_timeout_flag, next_interrupt_out_n;
	frontend_type next_frontend;

	// Compensation is subtracted from both capacitance times before the ratio; temperature times are used raw
	assign div_num = (state == ST_TEMP_DIV) ? ACC_W'(temp_sensor_time) :
		comp_sub(acc[port], comp_acc);
	assign div_den = (state == ST_TEMP_DIV) ? ACC_W'(temp_ref_time) :
		comp_sub(acc[0], comp_acc);

	always_comb begin
		next_state = state;
		next_port = port;
		next_phase = phase;
		next_in_comp = in_comp;
		next_temp_phase = temp_phase;
		next_block_cnt = block_cnt;
		next_temp_div_cnt = temp_div_cnt;
		next_acc = acc;
		next_comp_acc = comp_acc;
		next_temp_sensor_time = temp_sensor_time;
		next_temp_ref_time = temp_ref_time;
		next_cap_result = cap_result;
		next_ext_result = external_temp_ratio_result;
		next_int_result = internal_temp_ratio_result;
		next_busy = busy;
		next_timeout_flag = timeout_flag;
		next_interrupt_out_n = interrupt_out_n;
		next_frontend = frontend;
		next_launch = 1'b0;
		next_div_go = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (start_measurement) begin
					next_state = ST_CAP;
					next_port = 3'h0;
					next_phase = 2'h0;
					next_in_comp = 1'b0;
					next_block_cnt = 5'h00;
					for (int i = 0; i < 8; i++) begin
						next_acc[i] = '0;
					end
					next_comp_acc = '0;
					next_timeout_flag = 1'b0;
					next_busy = 1'b1;
					next_interrupt_out_n = 1'b1;
					next_launch = 1'b1;
					next_frontend = cap_frontend(3'h0, 2'h0, 1'b0, floating);
				end else if (start_temperature && !temp_trigger_cap) begin
					next_state = ST_TEMP;
					next_temp_phase = 1'b0;
					next_busy = 1'b1;
					next_interrupt_out_n = 1'b1;
					next_launch = 1'b1;
					next_frontend = temp_frontend(1'b0, temp_ext);
				end
			end
			ST_CAP: begin
				if (t_done) begin
					next_timeout_flag = timeout_flag | t_to;
					next_launch = 1'b1;
					if (in_comp) begin
						next_comp_acc = comp_acc + ACC_W'(t_time);
						// Fake blocks run the front end but are thrown away
						if (block_cnt < fake_blocks) begin
							for (int i = 0; i < 8; i++) begin
								next_acc[i] = '0;
							end
							next_comp_acc = '0;
						end
						if (block_cnt + 5'h01 == total_blocks) begin
							next_state = ST_CAP_DIV;
							next_port = 3'h1;
							next_launch = 1'b0;
							next_div_go = 1'b1;
							next_frontend = '0;
						end else begin
							next_block_cnt = block_cnt + 5'h01;
							next_port = 3'h0;
							next_phase = 2'h0;
							next_in_comp = 1'b0;
							next_frontend = cap_frontend(3'h0, 2'h0, 1'b0, floating);
						end
					end else begin
						if (floating && phase == 2'h2) begin
							next_acc[port] = acc[port] - ACC_W'(t_time);
						end else begin
							next_acc[port] = acc[port] + ACC_W'(t_time);
						end
						if (floating && phase != 2'h2) begin
							next_phase = phase + 2'h1;
							next_frontend = cap_frontend(port, phase + 2'h1, 1'b0, floating);
						end else if (port == last_port) begin
							next_in_comp = 1'b1;
							next_phase = 2'h0;
							next_frontend = cap_frontend(3'h0, 2'h0, 1'b1, floating);
						end else begin
							next_port = port + 3'h1;
							next_phase = 2'h0;
							next_frontend = cap_frontend(port + 3'h1, 2'h0, 1'b0, floating);
						end
					end
				end
			end
			ST_CAP_DIV: begin
				if (d_done) begin
					next_cap_result[port] = d_quo;
					if (port != last_port) begin
						next_port = port + 3'h1;
						next_div_go = 1'b1;
					end else if (temp_trigger_cap && temp_div_cnt >= temp_trigger_divider) begin
						next_temp_div_cnt = 10'h000;
						next_state = ST_TEMP;
						next_temp_phase = 1'b0;
						next_launch = 1'b1;
						next_frontend = temp_frontend(1'b0, temp_ext);
					end else begin
						if (temp_trigger_cap) begin
							next_temp_div_cnt = temp_div_cnt + 10'h001;
						end
						next_state = ST_IDLE;
						next_busy = 1'b0;
						next_interrupt_out_n = 1'b0;
					end
				end
			end
			ST_TEMP: begin
				if (t_done) begin
					if (!temp_phase) begin
						next_temp_sensor_time = t_time;
						next_temp_phase = 1'b1;
						next_launch = 1'b1;
						next_frontend = temp_frontend(1'b1, temp_ext);
					end else begin
						next_temp_ref_time = t_time;
						next_state = ST_TEMP_DIV;
						next_div_go = 1'b1;
						next_frontend = '0;
					end
				end
			end
			ST_TEMP_DIV: begin
				if (d_done) begin
					if (temp_ext) begin
						next_ext_result = d_quo;
					end else begin
						next_int_result = d_quo;
					end
					next_state = ST_IDLE;
					next_busy = 1'b0;
					next_interrupt_out_n = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			port <= 3'h0;
			phase <= 2'h0;
			in_comp <= 1'b0;
			temp_phase <= 1'b0;
			block_cnt <= 5'h00;
			temp_div_cnt <= 10'h000;
			for (int i = 0; i < 8; i++) begin
				acc[i] <= '0;
			end
			for (int i = 1; i < 8; i++) begin
				cap_result[i] <= '0;
			end
			comp_acc <= '0;
			temp_sensor_time <= '0;
			temp_ref_time <= '0;
			external_temp_ratio_result <= '0;
			internal_temp_ratio_result <= '0;
			busy <= 1'b0;
			timeout_flag <= 1'b0;
			interrupt_out_n <= 1'b1;
			frontend <= '0;
			launch <= 1'b0;
			div_go <= 1'b0;
		end else begin
			state <= next_state;
			port <= next_port;
			phase <= next_phase;
			in_comp <= next_in_comp;
			temp_phase <= next_temp_phase;
			block_cnt <= next_block_cnt;
			temp_div_cnt <= next_temp_div_cnt;
			acc <= next_acc;
			cap_result <= next_cap_result;
			comp_acc <= next_comp_acc;
			temp_sensor_time <= next_temp_sensor_time;
			temp_ref_time <= next_temp_ref_time;
			external_temp_ratio_result <= next_ext_result;
			internal_temp_ratio_result <= next_int_result;
			busy <= next_busy;
			timeout_flag <= next_timeout_flag;
			interrupt_out_n <= next_interrupt_out_n;
			frontend <= next_frontend;
			launch <= next_launch;
			div_go <= next_div_go;
		end
	end
endmodule

// ===== core/seq_defs.svh
// Offsets, field positions and codes of the measurement sequencer
// Assumes inclusion by every sequencer file that decodes registers
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// ****************************************
// Configuration write addresses
// ****************************************
`define ADDR_MEAS_CONFIG_A 6'h04
`define ADDR_MEAS_CONFIG_B 6'h05
`define ADDR_TEMP_CONFIG 6'h06

// ****************************************
// Result read addresses
// ****************************************
`define ADDR_STATUS 6'h00
`define ADDR_CAP_FIRST 6'h01
`define ADDR_CAP_LAST 6'h07
`define ADDR_EXT_TEMP 6'h0D
`define ADDR_INT_TEMP 6'h0E

// ****************************************
// Field positions
// ****************************************
`define CYCLE_TIME_MSB 23
`define CYCLE_TIME_LSB 8
`define TRIG_SRC_MSB 7
`define TRIG_SRC_LSB 0
`define TRIG_DIV_MSB 9
`define TRIG_DIV_LSB 0
`define FAKE_MSB 11
`define FAKE_LSB 10
`define AVG_MSB 15
`define AVG_LSB 12
`define SENSORS_MSB 18
`define SENSORS_LSB 16
`define RES_SEL_MSB 20
`define RES_SEL_LSB 19
`define FLOATING_BIT 21
`define TEMP_SEL_MSB 14
`define TEMP_SEL_LSB 8
`define STAT_BUSY 0
`define STAT_TIMEOUT 1

// ****************************************
// Codes and limits
// ****************************************
`define TRIG_SRC_CAP 8'h01
`define TEMP_SEL_EXT 7'h0C
`define TEMP_SEL_INT 7'h43
`define MAX_FLOAT_SENSORS 3'h3
`define RPORT_EXT_SENSOR 0
`define RPORT_EXT_REF 2
`define RPORT_INT_AL 3
`define RPORT_INT_POLY 4
`define FRAC_BITS 21

`endif

// ===== core/seq_pkg.sv
// Types shared by the measurement sequencer files
// Assumes seq_defs.svh holds all numeric constants except the state codes
package seq_pkg;
	typedef struct packed {
		logic [7:0] capacitive_port;
		logic [4:0] resistive_port;
		logic sensor_switch_high;
		logic sensor_switch_low;
	} frontend_type;

	typedef struct packed {
		logic en;
		logic [5:0] addr;
		logic [23:0] data;
	} cfg_write_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CAP = 5'h02,
		ST_CAP_DIV = 5'h04,
		ST_TEMP = 5'h08,
		ST_TEMP_DIV = 5'h10
	} seq_state_type;
endpackage

// ===== core/discharge_timer.sv
// Times one discharge inside one programmed cycle
// Assumes comp_high is already synchronised to clk_sys
module discharge_timer #(
	parameter int TIME_W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [TIME_W-1:0] cycle_limit,
	input wire logic comp_high,
	output logic discharge_en,
	output logic done,
	output logic [TIME_W-1:0] time_val,
	output logic timed_out
);
	logic running, next_running, stopped, next_stopped;
	logic next_discharge_en, next_done, next_timed_out;
	logic [TIME_W-1:0] cnt, next_cnt, next_time_val;

	always_comb begin
		next_running = running;
		next_stopped = stopped;
		next_discharge_en = discharge_en;
		next_done = 1'b0;
		next_timed_out = timed_out;
		next_cnt = cnt;
		next_time_val = time_val;
		if (start) begin
			next_running = 1'b1;
			next_stopped = 1'b0;
			next_discharge_en = 1'b1;
			next_cnt = '0;
		end else if (running) begin
			next_cnt = cnt + 1'b1;
			if (!stopped && !comp_high) begin
				next_stopped = 1'b1;
				next_discharge_en = 1'b0;
				next_time_val = cnt;
			end
			// Cycle ends on time whether or not discharge finished
			if (cnt == cycle_limit - 1'b1) begin
				next_running = 1'b0;
				next_discharge_en = 1'b0;
				next_done = 1'b1;
				next_timed_out = !next_stopped;
				if (!next_stopped) begin
					next_time_val = cycle_limit;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			running <= 1'b0;
			stopped <= 1'b0;
			discharge_en <= 1'b0;
			done <= 1'b0;
			timed_out <= 1'b0;
			cnt <= '0;
			time_val <= '0;
		end else begin
			running <= next_running;
			stopped <= next_stopped;
			discharge_en <= next_discharge_en;
			done <= next_done;
			timed_out <= next_timed_out;
			cnt <= next_cnt;
			time_val <= next_time_val;
		end
	end
endmodule

// ===== core/ratio_divider.sv
// Restoring divider giving numer / denom as unsigned fixed point
// Assumes start is a one-cycle pulse and operands hold until done
module ratio_divider #(
	parameter int NUM_W = 20,
	parameter int FRAC_W = 21,
	parameter int OUT_W = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [NUM_W-1:0] numer,
	input wire logic [NUM_W-1:0] denom,
	output logic done,
	output logic [OUT_W-1:0] quotient
);
	localparam int DW = NUM_W + FRAC_W;
	localparam int CW = $clog2(DW + 1);

	logic busy, next_busy, next_done;
	logic [CW-1:0] cnt, next_cnt;
	logic [NUM_W:0] rem, next_rem;
	logic [DW-1:0] dvd, next_dvd, quo, next_quo;
	logic [OUT_W-1:0] next_quotient;

	always_comb begin
		logic [NUM_W:0] trial;
		trial = '0;
		next_busy = busy;
		next_done = 1'b0;
		next_cnt = cnt;
		next_rem = rem;
		next_dvd = dvd;
		next_quo = quo;
		next_quotient = quotient;
		if (start) begin
			next_busy = 1'b1;
			next_cnt = '0;
			next_rem = '0;
			next_dvd = {numer, {FRAC_W{1'b0}}};
			next_quo = '0;
		end else if (busy) begin
			trial = {rem[NUM_W-1:0], dvd[DW-1]};
			next_dvd = {dvd[DW-2:0], 1'b0};
			if (trial >= {1'b0, denom}) begin
				next_rem = trial - {1'b0, denom};
				next_quo = {quo[DW-2:0], 1'b1};
			end else begin
				next_rem = trial;
				next_quo = {quo[DW-2:0], 1'b0};
			end
			next_cnt = cnt + 1'b1;
			if (cnt == CW'(DW - 1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
				// Saturate; a zero reference also lands here
				if (|next_quo[DW-1:OUT_W]) begin
					next_quotient = '1;
				end else begin
					next_quotient = next_quo[OUT_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= '0;
			rem <= '0;
			dvd <= '0;
			quo <= '0;
			quotient <= '0;
		end else begin
			busy <= next_busy;
			done <= next_done;
			cnt <= next_cnt;
			rem <= next_rem;
			dvd <= next_dvd;
			quo <= next_quo;
			quotient <= next_quotient;
		end
	end
endmodule

// ===== test/sensor_model.sv
// Comparator model of the sensors, reference and resistors
// Assumes one discharge per frontend setting while discharge_en is high
module sensor_model
	import seq_pkg::*;
(
	input wire logic clk_sys,
	input wire seq_pkg::frontend_type frontend,
	input wire logic discharge_en,
	input wire logic slow,
	output logic comparator_in
);
	timeunit 1ns;
	timeprecision 1ps;
	frontend_type last;
	int cnt = 0;
	int t;
	always_comb begin
		if (slow)
			t = 255;
		else if (frontend.resistive_port != 5'h00)
			t = 30;
		else if (frontend.capacitive_port == 8'h01)
			t = 24;
		else if (frontend.capacitive_port != 8'h00)
			t = 14;
		else
			t = 4;
	end
	// Times other than the slow one stay under half of a 64-cycle slot
	always @(posedge clk_sys) begin
		last <= frontend;
		cnt <= (discharge_en && frontend == last) ? cnt + 1 : 0;
	end
	assign comparator_in = !(discharge_en && cnt >= t);
endmodule

// ===== test/seq_assertions.sv
// Checker for the sequencer ports
// Assumes bind to the sequencer top
module seq_assertions
	import seq_pkg::*;
#(
	parameter int TIME_W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire seq_pkg::cfg_write_type cfg_write,
	input wire logic start_measurement,
	input wire logic start_temperature,
	input wire logic [5:0] rd_addr,
	input wire logic [23:0] rd_data,
	input wire logic comparator_in,
	input wire seq_pkg::frontend_type frontend,
	input wire logic discharge_en,
	input wire logic [1:0] discharge_resistor_select,
	input wire logic interrupt_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [TIME_W-1:0] lim;
	logic [TIME_W-1:0] run;
	logic [TIME_W-1:0] next_lim;
	logic [TIME_W-1:0] next_run;
	frontend_type last;
	always_comb begin
		next_lim = lim;
		if (cfg_write.en && cfg_write.addr == 6'h04)
			next_lim = cfg_write.data[8 +: TIME_W];
		next_run = '0;
		if (discharge_en && frontend.resistive_port == 5'h00 && frontend == last)
			next_run = run + 1'b1;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lim <= '0;
			run <= '0;
			last <= '0;
		end else begin
			lim <= next_lim;
			run <= next_run;
			last <= frontend;
		end
	end
	sequence s_accept;
		start_measurement && !interrupt_out_n;
	endsequence
	sequence s_ref_slot;
		interrupt_out_n && discharge_en && frontend.capacitive_port == 8'h01;
	endsequence
	property p_one_port;
		$onehot0(frontend.capacitive_port) && $onehot0(frontend.resistive_port)
			&& (frontend.capacitive_port == 8'h00 || frontend.resistive_port == 5'h00);
	endproperty
	a_one_port: assert property (p_one_port) else $error("two ports at once");
	property p_open_sw;
		discharge_en && frontend.capacitive_port == 8'h00 && frontend.resistive_port == 5'h00
			|-> !frontend.sensor_switch_high && !frontend.sensor_switch_low;
	endproperty
	a_open_sw: assert property (p_open_sw) else $error("switch closed");
	property p_res_sel;
		cfg_write.en && cfg_write.addr == 6'h05
			|=> discharge_resistor_select == $past(cfg_write.data[20:19]);
	endproperty
	a_res_sel: assert property (p_res_sel) else $error("resistor select");
	property p_first_slot;
		// Launch and timer start are both registered: discharge starts one cycle late
		s_accept |=> ##1 s_ref_slot;
	endproperty
	a_first_slot: assert property (p_first_slot) else $error("first slot");
	property p_irq_cause;
		$rose(interrupt_out_n) |-> $past(start_measurement) || $past(start_temperature);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose alone");
	property p_irq_hold;
		s_accept |=> interrupt_out_n [*8];
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq fell early");
	property p_slot_len;
		// A timed-out slot discharges for the full limit
		(lim == '0) ? (run <= 1) : (run <= lim);
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot too long");
	property p_idle_quiet;
		!interrupt_out_n |-> frontend.capacitive_port == 8'h00;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("port while idle");
endmodule
bind discharge_time_measurement_sequencer seq_assertions #(.TIME_W(TIME_W)) u_seq_assertions (
	.clk_sys(clk_sys), .rst_n(rst_n), .cfg_write(cfg_write),
	.start_measurement(start_measurement), .start_temperature(start_temperature),
	.rd_addr(rd_addr), .rd_data(rd_data), .comparator_in(comparator_in),
	.frontend(frontend), .discharge_en(discharge_en),
	.discharge_resistor_select(discharge_resistor_select), .interrupt_out_n(interrupt_out_n));

// ===== test/test_discharge_time_measurement_sequencer.sv
// Self-checking bench of the sequencer, one task per scenario
// Assumes sensor_model drives the comparator
module test_discharge_time_measurement_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import seq_pkg::*;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic start_measurement = 0;
	logic start_temperature = 0;
	logic slow = 0;
	logic comparator_in;
	logic discharge_en;
	logic interrupt_out_n;
	logic pe;
	logic [1:0] discharge_resistor_select;
	logic [5:0] rd_addr = 0;
	logic [23:0] rd_data;
	cfg_write_type cfg_write = '0;
	frontend_type frontend;
	frontend_type pf;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	int ns = 0;
	int nt = 0;
	int nx = 0;
	int ni = 0;
	always #2 clk_sys = !clk_sys;
	discharge_time_measurement_sequencer u_discharge_time_measurement_sequencer (
		.clk_sys(clk_sys), .rst_n(rst_n), .cfg_write(cfg_write),
		.start_measurement(start_measurement), .start_temperature(start_temperature),
		.rd_addr(rd_addr), .rd_data(rd_data), .comparator_in(comparator_in),
		.frontend(frontend), .discharge_en(discharge_en),
		.discharge_resistor_select(discharge_resistor_select), .interrupt_out_n(interrupt_out_n));
	sensor_model u_sensor_model (.clk_sys(clk_sys), .frontend(frontend),
		.discharge_en(discharge_en), .slow(slow), .comparator_in(comparator_in));
	// Slot and temperature-run counters
	always @(posedge clk_sys) begin
		if (discharge_en && frontend.resistive_port == 5'h00 && (frontend != pf || !pe)) ns++;
		if ((frontend.resistive_port[0] && !pf.resistive_port[0])
			|| (frontend.resistive_port[3] && !pf.resistive_port[3])) nt++;
		if (frontend.resistive_port[2:0] != 3'h0) nx++;
		if (frontend.resistive_port[4:3] != 2'h0) ni++;
		pf <= frontend;
		pe <= discharge_en;
		cyc++;
		if (cyc == 40000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge clk_sys) cfg_write <= '{1'b1, a, d};
		@(posedge clk_sys) cfg_write.en <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [23:0] exp);
		@(posedge clk_sys) rd_addr <= a;
		repeat (2) @(posedge clk_sys);
		chk(rd_data, exp);
	endtask
	task automatic clr();
		ns = 0;
		nt = 0;
		nx = 0;
		ni = 0;
	endtask
	// Waits on busy as well: the registered status read of busy lags the interrupt by one cycle
	task automatic run(input bit temp);
		int n;
		n = 0;
		@(posedge clk_sys) begin
			start_measurement <= !temp;
			start_temperature <= temp;
		end
		@(posedge clk_sys) begin
			start_measurement <= 1'b0;
			start_temperature <= 1'b0;
			rd_addr <= 6'h00;
		end
		repeat (3) @(posedge clk_sys);
		while ((interrupt_out_n !== 1'b0 || rd_data[0] !== 1'b0) && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 3000) failures++;
	endtask
	task automatic t_reset();
		chk(24'(interrupt_out_n), 24'h000001);
		chk(24'(discharge_resistor_select), 24'h000000);
		rd(6'h0D, 24'h000000);
	endtask
	task automatic t_resistor();
		for (int i = 0; i < 4; i++) begin
			wr(6'h05, 24'(i) << 19);
			@(posedge clk_sys);
			chk(24'(discharge_resistor_select), 24'(i));
		end
	endtask
	task automatic t_meas(input logic [23:0] b, input int slots, input logic [5:0] a);
		wr(6'h04, 24'h004000);
		wr(6'h05, b);
		clr();
		run(0);
		chk(24'(ns), 24'(slots));
		chk(24'(nt), 24'h000000);
		rd(a, 24'h100000);
		rd(6'h00, 24'h000000);
	endtask
	task automatic t_timeout();
		wr(6'h05, 24'h000000);
		slow <= 1'b1;
		run(0);
		rd(6'h00, 24'h000002);
		slow <= 1'b0;
		run(0);
		rd(6'h00, 24'h000000);
	endtask
	task automatic t_temp();
		wr(6'h04, 24'h004001);
		wr(6'h05, 24'h000000);
		wr(6'h06, 24'h000C40);
		clr();
		run(0);
		chk(24'(nt), 24'h000001);
		chk(24'(ni), 24'h000000);
		rd(6'h0D, 24'h200000);
		wr(6'h06, 24'h004340);
		clr();
		run(0);
		chk(24'(nx), 24'h000000);
		rd(6'h0E, 24'h200000);
		wr(6'h05, 24'h000002);
		clr();
		run(0);
		run(0);
		chk(24'(nt), 24'h000000);
		run(0);
		chk(24'(nt), 24'h000001);
		wr(6'h04, 24'h004000);
		clr();
		run(0);
		chk(24'(nt), 24'h000000);
		run(1);
		chk(24'(nt), 24'h000001);
	endtask
	task automatic end_sim();
		$display("failures=%0d checked=%0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_resistor();
		t_meas(24'h032400, 15, 6'h03);
		t_meas(24'h070000, 9, 6'h07);
		t_meas(24'h230000, 13, 6'h03);
		t_timeout();
		t_temp();
		end_sim();
	end
endmodule
